// ### logic/ftdio_pkg.sv
// Purpose: shared constants for the fast trip discrete io block
// Assumes: 125 MHz core clock, 32-bit Avalon-MM register bus
// Notes:   byte addresses are word aligned
package ftdio_pkg;
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned FILT_SHORT_NS   = 500_000;
  localparam int unsigned FILT_LONG_NS    = 1_500_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned FILT_SHORT_CYC  = (FILT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FILT_LONG_CYC   = (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NPTS            = 4;
  localparam int unsigned CNT_W           = 18;
  // register byte addresses
  localparam logic [3:0]  ADDR_CFG        = 4'h0;
  localparam logic [3:0]  ADDR_OUT_CMD    = 4'h4;
  localparam logic [3:0]  ADDR_IN_REG     = 4'h8;
  localparam logic [3:0]  ADDR_TIMEOUT    = 4'hC;
  // config fields
  localparam int unsigned CFG_DUAL_BIT    = 0;
  localparam int unsigned CFG_FILT_BIT    = 1;
  localparam int unsigned CFG_MAP_BIT     = 2;
  localparam int unsigned CFG_SUPV_BIT    = 3;
  // output command word: commands [3:0], fast trip enables [7:4]
  localparam int unsigned CMD_LSB         = 0;
  localparam int unsigned FTE_LSB         = 4;
  localparam logic [3:0]  TIMEOUT_RST     = 4'h0;
  localparam logic [31:0] UNMAPPED_RD     = 32'h0000_0000;
  typedef enum logic [1:0] {
    FTDIO_IDLE = 2'b01,
    FTDIO_RESP = 2'b10
  } ftdio_bus_st_t;
endpackage : ftdio_pkg

// ### logic/ftdio_top.sv
// Purpose: four in / four out discrete io with fast trip, filter and timeout state
// Assumes: field inputs synchronous to core_clk_i; supervision is a level input
// Notes:   Avalon-MM slave answers one cycle after a request is seen
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module ftdio_top
  import ftdio_pkg::*;
#(
  parameter int unsigned FILT_SHORT = FILT_SHORT_CYC,
  parameter int unsigned FILT_LONG  = FILT_LONG_CYC
) (
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  input  wire logic [3:0]           avs_byteenable_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // field side
  input  wire logic [ftdio_pkg::NPTS-1:0] field_in_i,
  input  wire logic                 supervised_i,
  output logic      [ftdio_pkg::NPTS-1:0] field_out_o,
  output logic      [ftdio_pkg::NPTS-1:0] in_filt_o
);
  import ftdio_pkg::*;

  logic [7:0]      cfg_r;
  logic [7:0]      out_cmd_r;
  logic [3:0]      timeout_r;
  logic [3:0]      filt_r;
  logic [3:0]      trip;
  logic [3:0]      out_nxt;
  logic [3:0]      out_r;
  logic [31:0]     rdata_nxt;
  logic [31:0]     rdata_r;
  ftdio_bus_st_t   bus_st_r;
  logic [CNT_W-1:0] filt_lim;

  wire logic       dual_en = cfg_r[CFG_DUAL_BIT];
  wire logic [3:0] cmd     = out_cmd_r[CMD_LSB +: NPTS];
  wire logic [3:0] fte     = out_cmd_r[FTE_LSB +: NPTS];
  wire logic       req     = avs_read_i | avs_write_i;

  // bus: requests held until waitrequest low, answered the cycle after
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      bus_st_r <= FTDIO_IDLE;
    else
    begin
      case (bus_st_r)
        FTDIO_IDLE: bus_st_r <= req ? FTDIO_RESP : FTDIO_IDLE;
        FTDIO_RESP: bus_st_r <= FTDIO_IDLE;
        default:    bus_st_r <= FTDIO_IDLE;
      endcase
    end
  end

  assign avs_waitrequest_o = ~(bus_st_r == FTDIO_RESP);
  wire logic wr_take = avs_write_i & (bus_st_r == FTDIO_RESP);

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cfg_r     <= 8'h00;
      out_cmd_r <= 8'h00;
      timeout_r <= TIMEOUT_RST;
    end
    else if (wr_take && avs_byteenable_i[0])
    begin
      case (avs_address_i)
        ADDR_CFG:     cfg_r     <= avs_writedata_i[7:0];
        ADDR_OUT_CMD: out_cmd_r <= avs_writedata_i[7:0];
        ADDR_TIMEOUT: timeout_r <= avs_writedata_i[3:0];
        default:      cfg_r     <= cfg_r;
      endcase
    end
  end

  // input register: filtered points [3:0] and output state [7:4], no status byte
  always_comb
  begin
    case (avs_address_i)
      ADDR_CFG:     rdata_nxt = {24'h000000, cfg_r};
      ADDR_OUT_CMD: rdata_nxt = {24'h000000, out_cmd_r};
      ADDR_IN_REG:  rdata_nxt = {24'h000000, out_r, filt_r};
      ADDR_TIMEOUT: rdata_nxt = {28'h0000000, timeout_r};
      default:      rdata_nxt = UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      rdata_r <= 32'h0000_0000;
    else if (bus_st_r == FTDIO_IDLE && avs_read_i)
      rdata_r <= rdata_nxt;
  end
  assign avs_readdata_o = rdata_r;

  // filter limit select
  assign filt_lim = cfg_r[CFG_FILT_BIT] ? CNT_W'(FILT_LONG) : CNT_W'(FILT_SHORT);

  genvar g;
  generate
    for (g = 0; g < NPTS; g++)
    begin : g_filt
      logic [CNT_W-1:0] cnt_r;
      always_ff @(posedge core_clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          cnt_r     <= '0;
          filt_r[g] <= 1'b0;
        end
        else if (field_in_i[g] == filt_r[g])
          cnt_r <= '0;
        else if (cnt_r + CNT_W'(1) >= filt_lim)
        begin
          cnt_r     <= '0;
          filt_r[g] <= field_in_i[g];
        end
        else
          cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  endgenerate

  // trip paths
  always_comb
  begin
    if (dual_en)
    begin
      trip[0] = &filt_r[1:0] & &fte[1:0];
      trip[1] = 1'b0;
      trip[2] = &filt_r[3:2] & &fte[3:2];
      trip[3] = 1'b0;
    end
    else
      trip = filt_r & fte;
  end

  assign out_nxt = supervised_i ? (cmd | trip) : timeout_r;

  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      out_r <= TIMEOUT_RST;
    else
      out_r <= out_nxt;
  end

  assign field_out_o = out_r;
  assign in_filt_o   = filt_r;

  // assertions
  a_dual_out_one: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    supervised_i && dual_en && (cmd[0] || (&filt_r[1:0] && &fte[1:0])) |=> out_r[0])
    else $error("output 1 missed dual trip");
  a_dual_out_three: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    supervised_i && dual_en && (cmd[2] || (&filt_r[3:2] && &fte[3:2])) |=> out_r[2])
    else $error("output 3 missed dual trip");
  a_dual_even_cmd: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    supervised_i && dual_en |=> (out_r[1] == $past(cmd[1])) && (out_r[3] == $past(cmd[3])))
    else $error("even output not following command");
  a_fast_trip_or: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    supervised_i && !dual_en |=> out_r == ($past(cmd) | ($past(filt_r) & $past(fte))))
    else $error("fast trip output wrong");
  a_timeout_state: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !supervised_i |=> field_out_o == $past(timeout_r))
    else $error("timeout state not applied");
  a_filter_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(filt_r[0]) |-> $past(field_in_i[0]) == filt_r[0])
    else $error("filter changed without input");
  a_filter_short: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ($past(!cfg_r[CFG_FILT_BIT]) && g_filt[0].cnt_r != '0) |-> g_filt[0].cnt_r < CNT_W'(FILT_SHORT))
    else $error("short filter count overrun");
  a_no_status: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !avs_waitrequest_o && $past(avs_read_i) && $past(avs_address_i) == ADDR_IN_REG
    |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("status bits in input register");
  a_bus_answer: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (bus_st_r == FTDIO_IDLE) && req |=> !avs_waitrequest_o)
    else $error("bus answer late");

  // assertion helper: cycles raw point 1 has held its level
  logic             hold_prev_r;
  logic [CNT_W-1:0] hold_cnt_r;
  always_ff @(posedge core_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      hold_prev_r <= 1'b0;
      hold_cnt_r  <= '0;
    end
    else
    begin
      hold_prev_r <= field_in_i[0];
      if (field_in_i[0] != hold_prev_r)
        hold_cnt_r <= CNT_W'(1);
      else if (hold_cnt_r != '1)
        hold_cnt_r <= hold_cnt_r + CNT_W'(1);
    end
  end

  a_filter_settle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $changed(filt_r[0]) |-> hold_cnt_r >= $past(filt_lim))
    else $error("filter changed before input settled");
  a_filter_long: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ($past(cfg_r[CFG_FILT_BIT]) && g_filt[0].cnt_r != '0) |-> g_filt[0].cnt_r < CNT_W'(FILT_LONG))
    else $error("long filter count overrun");
  a_dual_one_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    supervised_i && dual_en && !cmd[0] && !(&filt_r[1:0] && &fte[1:0]) |=> !out_r[0])
    else $error("output 1 on without cause");
  a_dual_three_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    supervised_i && dual_en && !cmd[2] && !(&filt_r[3:2] && &fte[3:2]) |=> !out_r[2])
    else $error("output 3 on without cause");
  a_wait_one: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  a_in_reg_pts: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!avs_waitrequest_o && $past(avs_read_i) && ($past(avs_address_i) == ADDR_IN_REG))
    |-> avs_readdata_o[7:0] == $past({out_r, filt_r}))
    else $error("input register content wrong");
endmodule : ftdio_top

// ### test/ftdio_ctrl_model.sv
// Purpose: controller model driving the register bus and supervision level
// Assumes: slave answers each request with one low cycle of waitrequest
// Notes:   requests use word-aligned addresses, except the unmapped read at 4'h2
`timescale 1ns/1ps
module ftdio_ctrl_model (
  // clock
  input  wire logic        clk_i,
  // avalon-mm master
  input  wire logic [31:0] rdata_i,
  input  wire logic        wait_i,
  output logic      [3:0]  addr_o = 4'h0,
  output logic             rd_o = 1'b0,
  output logic             wr_o = 1'b0,
  output logic      [31:0] wdata_o = 32'h0,
  output logic      [3:0]  be_o = 4'hF,
  // supervision
  output logic             supv_o = 1'b1
);
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    addr_o  <= a;
    rd_o    <= !w;
    wr_o    <= w;
    wdata_o <= d;
    do @(posedge clk_i); while (wait_i !== 1'b0);
    q = rdata_i;
    rd_o    <= 1'b0;
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : xfer
  task automatic set_supv(input logic v);
    @(posedge clk_i);
    supv_o <= v;
  endtask : set_supv
endmodule : ftdio_ctrl_model

// ### test/testbench.sv
// Purpose: self-checking bench for the fast trip discrete io block
// Assumes: filter counts shortened to 4 and 12 cycles
// Notes:   controller side lives in ftdio_ctrl_model
`timescale 1ns/1ps
module testbench;
  import ftdio_pkg::*;
  localparam int unsigned FS = 4;
  localparam int unsigned FL = 12;
  logic        clk;
  logic        rst;
  logic [3:0]  addr;
  logic        rd;
  logic        wr;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wreq;
  logic [3:0]  fin;
  logic        supv;
  logic [3:0]  fout;
  logic [3:0]  filt;
  logic [31:0] q;
  int          num_errors = 0;
  int          check_count = 0;
  ftdio_ctrl_model ctl (.clk_i(clk), .rdata_i(rdata), .wait_i(wreq), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wdata), .be_o(be), .supv_o(supv));
  ftdio_top #(.FILT_SHORT(FS), .FILT_LONG(FL)) dut (.core_clk_i(clk), .sys_rst_i(rst),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .field_in_i(fin), .supervised_i(supv), .field_out_o(fout), .in_filt_o(filt));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    ctl.xfer(1'b1, a, d, q);
  endtask : wr_reg
  task automatic rd_chk(input string n, input logic [3:0] a, input logic [31:0] e);
    ctl.xfer(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask : rd_chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic drive_in(input logic [3:0] v, input int n);
    @(posedge clk);
    fin <= v;
    wait_cyc(n);
  endtask : drive_in
  task automatic test_reset();
    rd_chk("in_reg", ADDR_IN_REG, 32'h0);
    rd_chk("timeout", ADDR_TIMEOUT, 32'h0);
    rd_chk("unmapped", 4'h2, UNMAPPED_RD);
    wr_reg(ADDR_OUT_CMD, 32'h0F);
    ctl.set_supv(1'b0);
    wait_cyc(3);
    chk("default_timeout", 4'h0, fout);
    ctl.set_supv(1'b1);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_fast();
    wr_reg(ADDR_CFG, 32'h0);
    wr_reg(ADDR_OUT_CMD, 32'h30);
    drive_in(4'h7, FS - 2);
    chk("filt_early", 4'h0, filt);
    wait_cyc(8);
    chk("filt_late", 4'h7, filt);
    chk("trip_out", 4'h3, fout);
    rd_chk("in_reg", ADDR_IN_REG, 32'h37);
    wr_reg(ADDR_OUT_CMD, 32'h38);
    drive_in(4'h0, FS + 6);
    chk("cmd_out", 4'h8, fout);
    $display("test_fast done");
  endtask : test_fast
  task automatic test_dual();
    logic [3:0] ins [5] = '{4'h3, 4'hC, 4'h2, 4'hA, 4'hF};
    logic [3:0] exps [5] = '{4'h1, 4'h4, 4'h0, 4'h0, 4'h5};
    wr_reg(ADDR_CFG, 32'h1);
    wr_reg(ADDR_OUT_CMD, 32'hF0);
    for (int i = 0; i < 5; i++)
    begin
      drive_in(ins[i], FS + 6);
      chk("dual_trip", exps[i], fout);
    end
    drive_in(4'h0, FS + 6);
    wr_reg(ADDR_OUT_CMD, 32'hFE);
    wait_cyc(3);
    chk("dual_cmd", 4'hE, fout);
    $display("test_dual done");
  endtask : test_dual
  task automatic test_long();
    wr_reg(ADDR_CFG, 32'h2);
    drive_in(4'h1, FS + 6);
    chk("long_early", 4'h0, filt);
    wait_cyc(FL);
    chk("long_late", 4'h1, filt);
    drive_in(4'h0, FL + 6);
    $display("test_long done");
  endtask : test_long
  task automatic test_timeout();
    wr_reg(ADDR_TIMEOUT, 32'h9);
    wr_reg(ADDR_OUT_CMD, 32'h06);
    ctl.set_supv(1'b0);
    wait_cyc(3);
    chk("timeout_out", 4'h9, fout);
    rd_chk("timeout_reg", ADDR_TIMEOUT, 32'h9);
    ctl.set_supv(1'b1);
    wait_cyc(3);
    chk("resume_out", 4'h6, fout);
    $display("test_timeout done");
  endtask : test_timeout
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  initial
  begin
    wait_cyc(3000);
    num_errors++;
    $display("watchdog expired");
    finish_test();
  end
  initial
  begin
    rst = 1'b1;
    fin = 4'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_fast();
    test_dual();
    test_long();
    test_timeout();
    finish_test();
  end
endmodule : testbench
